//--- rtl/mtu_defines.svh
`ifndef MTU_DEFINES_SVH
`define MTU_DEFINES_SVH

// Register offsets on the control port
`define MTU_ADDR_GAIN       8'hE2
`define MTU_ADDR_TXBYTE     8'hE3
`define MTU_ADDR_FRAMING    8'hE4

// Gain register fields
`define MTU_RXG_LSB         0
`define MTU_TXG_LSB         4

// Framing register fields
`define MTU_FRM_SEL_BIT     5
`define MTU_STOP_HI_BIT     4
`define MTU_STOP_LO_BIT     3
`define MTU_PAR_EN_BIT      2
`define MTU_PAR_ODD_BIT     1
`define MTU_SEVEN_BIT       0

// Reset values
`define MTU_GAIN_RST        8'h00
`define MTU_FRAMING_RST     8'h00

// Phase advance in quarter turns
`define MTU_PH_0            2'h0
`define MTU_PH_90           2'h1
`define MTU_PH_180          2'h2
`define MTU_PH_270          2'h3

`endif

//--- rtl/mtu_pkg.sv
package mtu_pkg;

   typedef enum logic [2:0] {
      MTU_TX_IDLE  = 3'b000,
      MTU_TX_START = 3'b001,
      MTU_TX_DATA  = 3'b010,
      MTU_TX_PAR   = 3'b011,
      MTU_TX_STOP  = 3'b100
   } mtu_tx_state_t;

   typedef enum logic [1:0] {
      MTU_RX_IDLE = 2'b00,
      MTU_RX_DATA = 2'b01,
      MTU_RX_PAR  = 2'b10
   } mtu_rx_state_t;

endpackage

//--- rtl/mtu_modem_uart.sv
// Contract
// [RL1] Receive gain code comes from gain register bits 3..0.
// [RL2] Transmit gain from bits 7..4; code zero mutes output at bias.
// [RL3] Host should pick receive gain during calibration.
// [RL4] Transmit byte is double buffered; host refills within eight bits.
// [RL5] Byte sent as four dibits, least significant dibit first.
// [RL6] Dibit 00 gives +90, 01 none, 10 +180, 11 +270 degrees.
// [RL7] Left-hand bit of each dibit is sent first.
// [RL8] Framing select zero: plain 8-bit data, nothing added or removed.
// [RL9] Framing select one: start bit, data, optional parity, stop bits.
// [RL10] Host keeps framing select clear until handshaking completes.
// [RL11] Stop bits after character: 00 none, 01/10 one, 11 two.
// [RL12] Receiver needs no stop bits between characters.
// [RL13] Parity enable adds parity on transmit, expects it on receive.
// [RL14] Parity select one is odd, zero is even, both directions.
// [RL15] Seven-bit mode uses byte bits 0..6, else eight bits.
// [RL16] Host writes zero to framing register bits 7 and 6.
// [RL17] Seven-bit transmit ignores bit 7 and excludes it from parity.
`timescale 1ns/1ps
`include "mtu_defines.svh"

module mtu_modem_uart (
   input  wire logic       SYS_CLK,
   input  wire logic       RST_N,
   input  wire logic       REG_WR,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   input  wire logic       BIT_TICK,
   input  wire logic       RX_TICK,
   input  wire logic       RX_BIT,
   output logic            TX_BIT,
   output logic [1:0]      TX_PHASE,
   output logic            TX_PHASE_STB,
   output logic            TX_READY,
   output logic [7:0]      RX_DATA,
   output logic            RX_VALID,
   output logic            RX_PAR_ERR,
   output logic [3:0]      RX_GAIN_CODE,
   output logic [3:0]      TX_GAIN_CODE,
   output logic            TX_MUTE
);

   // Serial order within a byte with framing select zero: 1,0,3,2,5,4,7,6
   function automatic logic [2:0] dibit_pos(input logic [2:0] k);
      return {k[2:1], ~k[0]};
   endfunction

   function automatic logic [1:0] phase_of(input logic [1:0] d);
      logic [1:0] p;
      p = `MTU_PH_0;
      unique case (d)
         2'b00: p = `MTU_PH_90;
         2'b01: p = `MTU_PH_0;
         2'b10: p = `MTU_PH_180;
         2'b11: p = `MTU_PH_270;
      endcase
      return p;
   endfunction

   logic [7:0]             framing, hold, shift;
   logic                   shift_par, half, first_bit;
   mtu_pkg::mtu_tx_state_t tx_state, next_state;
   logic [2:0]             tx_cnt, next_cnt;
   logic                   fetch, next_bit;
   mtu_pkg::mtu_rx_state_t rx_state, next_rx_state;
   logic [2:0]             rx_cnt, next_rx_cnt, rx_idx;
   logic [7:0]             rx_shift, next_rx_shift;
   logic                   rx_cap, rx_done, rx_chk;

   wire wr_gain    = REG_WR && (REG_ADDR == `MTU_ADDR_GAIN);
   wire wr_txbyte  = REG_WR && (REG_ADDR == `MTU_ADDR_TXBYTE);
   wire wr_framing = REG_WR && (REG_ADDR == `MTU_ADDR_FRAMING);

   wire       async_on = framing[`MTU_FRM_SEL_BIT];
   wire       par_en   = async_on && framing[`MTU_PAR_EN_BIT];
   wire       par_odd  = framing[`MTU_PAR_ODD_BIT];
   // Seven-bit width only matters once framing is on
   wire       seven    = async_on && framing[`MTU_SEVEN_BIT];         // [RL15]
   wire [1:0] stop_cnt = {framing[`MTU_STOP_HI_BIT] &
                          framing[`MTU_STOP_LO_BIT],
                          framing[`MTU_STOP_HI_BIT] ^
                          framing[`MTU_STOP_LO_BIT]};                 // [RL11]
   wire [2:0] last_idx = seven ? 3'h6 : 3'h7;
   wire [7:0] hold_use = seven ? {1'b0, hold[6:0]} : hold;           // [RL17]
   wire       hold_par = (^hold_use) ^ par_odd;                      // [RL14]
   wire       tx_load  = fetch && !TX_READY;
   wire [7:0] tx_src   = tx_load ? hold : shift;
   wire [2:0] bit_sel  = async_on ? next_cnt : dibit_pos(next_cnt);  // [RL5]

   // Registers: gain and framing are write-only from the host side
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         RX_GAIN_CODE <= 4'(`MTU_GAIN_RST >> `MTU_RXG_LSB);
         TX_GAIN_CODE <= 4'(`MTU_GAIN_RST >> `MTU_TXG_LSB);
         TX_MUTE      <= 1'b1;
         framing      <= `MTU_FRAMING_RST;
      end else begin
         if (wr_gain) begin
            RX_GAIN_CODE <= REG_WDATA[`MTU_RXG_LSB +: 4];            // [RL1]
            TX_GAIN_CODE <= REG_WDATA[`MTU_TXG_LSB +: 4];            // [RL2]
            TX_MUTE      <= (REG_WDATA[`MTU_TXG_LSB +: 4] == 4'h0);  // [RL2]
         end
         // Reserved bits are stored as written; only bits 5..0 steer logic
         if (wr_framing) begin
            framing <= REG_WDATA;
         end
      end
   end

   // Holding stage; a write in the cycle of a load wins so no byte is lost
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         hold     <= 8'h00;
         TX_READY <= 1'b1;
      end else if (wr_txbyte) begin
         hold     <= REG_WDATA;
         TX_READY <= 1'b0;                                           // [RL4]
      end else if (BIT_TICK && tx_load) begin
         TX_READY <= 1'b1;                                           // [RL4]
      end
   end

   // Next element of the transmit stream, chosen at each bit boundary
   always_comb begin
      next_state = tx_state;
      next_cnt   = tx_cnt;
      fetch      = 1'b0;
      unique case (tx_state)
         mtu_pkg::MTU_TX_IDLE: fetch = 1'b1;
         mtu_pkg::MTU_TX_START: begin
            next_state = mtu_pkg::MTU_TX_DATA;
            next_cnt   = 3'h0;
         end
         mtu_pkg::MTU_TX_DATA: begin
            if (tx_cnt != last_idx) begin
               next_cnt = tx_cnt + 3'h1;
            end else if (!async_on) begin
               fetch = 1'b1;                                         // [RL8]
            end else if (par_en) begin
               next_state = mtu_pkg::MTU_TX_PAR;                     // [RL13]
            end else if (stop_cnt != 2'h0) begin
               next_state = mtu_pkg::MTU_TX_STOP;
               next_cnt   = 3'h0;
            end else begin
               fetch = 1'b1;
            end
         end
         mtu_pkg::MTU_TX_PAR: begin
            if (stop_cnt != 2'h0) begin
               next_state = mtu_pkg::MTU_TX_STOP;                    // [RL11]
               next_cnt   = 3'h0;
            end else begin
               fetch = 1'b1;
            end
         end
         mtu_pkg::MTU_TX_STOP: begin
            if (!tx_cnt[0] && stop_cnt == 2'h2) begin
               next_cnt = 3'h1;                                      // [RL11]
            end else begin
               fetch = 1'b1;
            end
         end
         default: next_state = mtu_pkg::MTU_TX_IDLE;
      endcase
      if (fetch) begin
         if (!TX_READY) begin
            next_state = async_on ? mtu_pkg::MTU_TX_START
                                  : mtu_pkg::MTU_TX_DATA;            // [RL9]
            next_cnt   = 3'h0;
         end else begin
            next_state = mtu_pkg::MTU_TX_IDLE;
         end
      end
   end

   // Line idles at mark between bytes
   always_comb begin
      unique case (next_state)
         mtu_pkg::MTU_TX_START: next_bit = 1'b0;                     // [RL9]
         mtu_pkg::MTU_TX_DATA:  next_bit = tx_src[bit_sel];          // [RL7]
         mtu_pkg::MTU_TX_PAR:   next_bit = shift_par;                // [RL13]
         default:               next_bit = 1'b1;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         tx_state  <= mtu_pkg::MTU_TX_IDLE;
         tx_cnt    <= 3'h0;
         TX_BIT    <= 1'b1;
         shift     <= 8'h00;
         shift_par <= 1'b0;
      end else if (BIT_TICK) begin
         tx_state <= next_state;
         tx_cnt   <= next_cnt;
         TX_BIT   <= next_bit;
         if (tx_load) begin
            shift     <= hold;
            shift_par <= hold_par;
         end
      end
   end

   // Pair stream bits into phase advances; idle marks keep the pairing
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         half         <= 1'b0;
         first_bit    <= 1'b0;
         TX_PHASE     <= `MTU_PH_0;
         TX_PHASE_STB <= 1'b0;
      end else begin
         TX_PHASE_STB <= 1'b0;
         if (BIT_TICK) begin
            half <= ~half;
            if (!half) begin
               first_bit <= next_bit;
            end else begin
               TX_PHASE     <= phase_of({first_bit, next_bit});      // [RL6]
               TX_PHASE_STB <= 1'b1;
            end
         end
      end
   end

   // Receiver: hunts a start bit only when framing is on
   always_comb begin
      next_rx_state = rx_state;
      next_rx_cnt   = rx_cnt;
      rx_cap        = 1'b0;
      rx_done       = 1'b0;
      rx_chk        = 1'b0;
      rx_idx        = 3'h0;
      unique case (rx_state)
         mtu_pkg::MTU_RX_IDLE: begin
            if (!async_on) begin
               rx_cap        = 1'b1;
               rx_idx        = dibit_pos(3'h0);
               next_rx_cnt   = 3'h1;
               next_rx_state = mtu_pkg::MTU_RX_DATA;
            end else if (!RX_BIT) begin
               next_rx_cnt   = 3'h0;
               next_rx_state = mtu_pkg::MTU_RX_DATA;                 // [RL12]
            end
         end
         mtu_pkg::MTU_RX_DATA: begin
            rx_cap = 1'b1;
            rx_idx = async_on ? rx_cnt : dibit_pos(rx_cnt);
            if (rx_cnt != last_idx) begin
               next_rx_cnt = rx_cnt + 3'h1;
            end else if (par_en) begin
               next_rx_state = mtu_pkg::MTU_RX_PAR;                  // [RL13]
            end else begin
               rx_done = 1'b1;
            end
         end
         mtu_pkg::MTU_RX_PAR: begin
            rx_chk  = 1'b1;
            rx_done = 1'b1;
         end
         default: next_rx_state = mtu_pkg::MTU_RX_IDLE;
      endcase
      if (rx_done) begin
         // No stop bit is awaited: the next start may follow at once
         next_rx_state = async_on ? mtu_pkg::MTU_RX_IDLE
                                  : mtu_pkg::MTU_RX_DATA;            // [RL12]
         next_rx_cnt   = 3'h0;
      end
   end

   always_comb begin
      next_rx_shift = rx_shift;
      if (rx_cap) begin
         next_rx_shift[rx_idx] = RX_BIT;
      end
      if (seven) begin
         next_rx_shift[7] = 1'b0;                                    // [RL15]
      end
   end

   wire rx_par_bad = rx_chk && (RX_BIT != ((^next_rx_shift) ^ par_odd));

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rx_state   <= mtu_pkg::MTU_RX_IDLE;
         rx_cnt     <= 3'h0;
         rx_shift   <= 8'h00;
         RX_DATA    <= 8'h00;
         RX_VALID   <= 1'b0;
         RX_PAR_ERR <= 1'b0;
      end else begin
         RX_VALID <= 1'b0;
         if (RX_TICK) begin
            rx_state <= next_rx_state;
            rx_cnt   <= next_rx_cnt;
            rx_shift <= next_rx_shift;
            if (rx_done) begin
               RX_DATA    <= next_rx_shift;
               RX_VALID   <= 1'b1;
               RX_PAR_ERR <= rx_par_bad;                             // [RL14]
            end
         end
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_load_sync;
      BIT_TICK && tx_load && !async_on;
   endsequence
   a_rx_gain_write: assert property (wr_gain |=>                     // [RL1]
      RX_GAIN_CODE == $past(REG_WDATA[3:0]))
      else $error("rx gain not taken from bits 3..0");
   a_tx_gain_mute: assert property (wr_gain |=>                      // [RL2]
      TX_GAIN_CODE == $past(REG_WDATA[7:4]) &&
      TX_MUTE == ($past(REG_WDATA[7:4]) == 4'h0))
      else $error("tx gain or mute wrong after write");
   a_buffer_full: assert property (wr_txbyte |=> !TX_READY)          // [RL4]
      else $error("holding stage not marked full");
   a_sync_first: assert property (s_load_sync |=>                    // [RL5]
      TX_BIT == $past(hold[1]) && tx_state == mtu_pkg::MTU_TX_DATA)
      else $error("sync byte not started with bit 1");
   a_phase_map: assert property (TX_PHASE_STB |->                    // [RL6]
      TX_PHASE == phase_of({$past(TX_BIT), TX_BIT}))
      else $error("phase advance does not match dibit");
   a_start_zero: assert property (BIT_TICK && tx_load && async_on    // [RL9]
      |=> TX_BIT == 1'b0 ##0 tx_state == mtu_pkg::MTU_TX_START)
      else $error("framed character lacks start bit");
   a_stop_mark: assert property (tx_state == mtu_pkg::MTU_TX_STOP    // [RL11]
      |-> TX_BIT)
      else $error("stop bit not at mark");
   a_parity_slot: assert property (BIT_TICK && par_en &&             // [RL13]
      tx_state == mtu_pkg::MTU_TX_DATA && tx_cnt == last_idx
      |=> tx_state == mtu_pkg::MTU_TX_PAR && TX_BIT == shift_par)
      else $error("parity bit missing after data");
   a_rx_seven: assert property (RX_VALID && $past(seven)             // [RL15]
      |-> RX_DATA[7] == 1'b0)
      else $error("seven-bit character has bit 7 set");
endmodule

//--- test/mtu_mod_model.sv
`timescale 1ns/1ps
module mtu_mod_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       tx_bit,
   input  wire logic [1:0] tx_phase,
   input  wire logic       tx_phase_stb,
   output logic            bit_tick,
   output logic            rx_tick,
   output logic            rx_bit,
   output logic            cap_stb,
   output logic            cap_bit,
   output int              ph_bad,
   output int              ph_cnt
);
   logic [2:0] div;
   logic       prev;
   logic [1:0] want;
   // Earlier bit of the pair is the left one
   assign want = ({prev, tx_bit} == 2'b00) ? 2'h1 :
                 ({prev, tx_bit} == 2'b01) ? 2'h0 : {prev, tx_bit};
   // Eight clocks per bit keeps the run short
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div      <= 3'h0;
         prev     <= 1'b1;
         bit_tick <= 1'b0;
         rx_tick  <= 1'b0;
         rx_bit   <= 1'b1;
         cap_stb  <= 1'b0;
         cap_bit  <= 1'b1;
         ph_bad   <= 0;
         ph_cnt   <= 0;
      end else begin
         div      <= div + 3'h1;
         bit_tick <= (div == 3'h7);
         cap_stb  <= (div == 3'h1);
         cap_bit  <= tx_bit;
         rx_tick  <= (div == 3'h1);
         // Loopback bit is only meaningful with its tick
         rx_bit   <= (div == 3'h1) ? tx_bit : ~rx_bit;
         if (cap_stb) begin
            prev <= cap_bit;
         end
         if (tx_phase_stb) begin
            ph_cnt <= ph_cnt + 1;
            if (tx_phase !== want) begin
               ph_bad <= ph_bad + 1;
            end
         end
      end
   end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
module tb;
   logic        sys_clk, rst_n, reg_wr, bit_tick, rx_tick, rx_bit;
   logic [7:0]  reg_addr, reg_wdata, rx_data;
   logic        tx_bit, tx_phase_stb, tx_ready, rx_valid, rx_par_err, tx_mute;
   logic [1:0]  tx_phase;
   logic [3:0]  rx_gain_code, tx_gain_code;
   logic        cap_stb, cap_bit;
   int          ph_bad, ph_cnt, error_cnt, n_compared, n_exp;
   logic [63:0] want;
   logic [7:0]  frm [5];
   logic [7:0]  gv [4];

   mtu_modem_uart dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .REG_WR(reg_wr),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .BIT_TICK(bit_tick),
      .RX_TICK(rx_tick), .RX_BIT(rx_bit), .TX_BIT(tx_bit),
      .TX_PHASE(tx_phase), .TX_PHASE_STB(tx_phase_stb), .TX_READY(tx_ready),
      .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_PAR_ERR(rx_par_err),
      .RX_GAIN_CODE(rx_gain_code), .TX_GAIN_CODE(tx_gain_code),
      .TX_MUTE(tx_mute));
   mtu_mod_model u_mod (.clk(sys_clk), .rst_n(rst_n), .tx_bit(tx_bit),
      .tx_phase(tx_phase), .tx_phase_stb(tx_phase_stb), .bit_tick(bit_tick),
      .rx_tick(rx_tick), .rx_bit(rx_bit), .cap_stb(cap_stb),
      .cap_bit(cap_bit), .ph_bad(ph_bad), .ph_cnt(ph_cnt));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] e,
                      input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic wait_ready;
      int t;
      t = 0;
      @(negedge sys_clk);
      while (tx_ready !== 1'b1 && t < 400) begin
         @(negedge sys_clk);
         t++;
      end
      chk("tx_ready_rise", 1, tx_ready);
   endtask

   task automatic add(input logic b);
      want[n_exp] = b;
      n_exp++;
   endtask

   // Expected stream of one character in the given framing
   task automatic frame(input logic [7:0] fr, input logic [7:0] d);
      int  nb;
      int  ns;
      logic p;
      nb = fr[0] ? 7 : 8;
      ns = (fr[4] & fr[3]) ? 2 : (fr[4] | fr[3]) ? 1 : 0;
      p  = fr[1];
      if (!fr[5]) begin
         for (int i = 0; i < 8; i += 2) begin
            add(d[i+1]);
            add(d[i]);
         end
      end else begin
         add(1'b0);
         for (int i = 0; i < nb; i++) begin
            add(d[i]);
            p ^= d[i];
         end
         if (fr[2]) add(p);
         for (int i = 0; i < ns; i++) add(1'b1);
      end
   endtask

   // Gathers the stream from its first zero bit on
   task automatic collect(input string what);
      logic [63:0] got;
      int          k;
      int          t;
      got = '0;
      k = 0;
      t = 0;
      while (k < n_exp && t < 4000) begin
         @(negedge sys_clk);
         t++;
         if (cap_stb === 1'b1 && (k > 0 || cap_bit === 1'b0)) begin
            got[k] = cap_bit;
            k++;
         end
      end
      chk(what, want, got);
   endtask

   task automatic send_pair(input logic [7:0] fr, input logic [7:0] a,
                            input logic [7:0] b);
      n_exp = 0;
      want = '0;
      wr(8'hE4, fr);
      // A receiver left mid-byte by sync mode must finish and start hunting
      repeat (96) @(negedge sys_clk);
      frame(fr, a);
      frame(fr, b);
      if (!fr[5]) begin
         add(1'b1);
         add(1'b1);
      end
      fork
         begin
            wr(8'hE3, a);
            wait_ready();
            wr(8'hE3, b);
            @(negedge sys_clk);
            chk("tx_ready_full", 0, tx_ready);
            wait_ready();
         end
         collect("tx_stream");
      join
      repeat (40) @(negedge sys_clk);
      if (fr[5]) begin
         chk("rx_data", fr[0] ? {1'b0, b[6:0]} : b, rx_data);
         chk("rx_par_err", 0, rx_par_err);
      end
      $display("test framing %h done", fr);
   endtask

   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end

   initial begin
      frm = '{8'h20, 8'h2C, 8'h36, 8'h3F, 8'h25};
      gv = '{8'hA5, 8'h00, 8'h1F, 8'hF0};
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      error_cnt = 0;
      n_compared = 0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
      chk("reset_outs", 14'h3009, {tx_ready, tx_mute, tx_gain_code,
          rx_gain_code, tx_bit, rx_valid, rx_par_err, 1'b1});
      $display("test reset done");
      foreach (gv[i]) begin
         wr(8'hE2, gv[i]);
         @(negedge sys_clk);
         chk("gain_codes", {gv[i], gv[i][7:4] == 4'h0},
             {tx_gain_code, rx_gain_code, tx_mute});
      end
      wr(8'hE1, 8'h0F);
      wr(8'hE5, 8'h0F);
      @(negedge sys_clk);
      chk("gain_unmapped", 8'hF0, {tx_gain_code, rx_gain_code});
      $display("test gain done");
      send_pair(8'h00, 8'hB4, 8'h6D);
      foreach (frm[i]) send_pair(frm[i], 8'hC5, 8'h3A);
      chk("phase_bad", 0, ph_bad);
      chk("phase_seen", 1, ph_cnt > 0);
      end_sim();
   end
endmodule
